//--- verilog/pixel_edge_mask_unit.sv
// Contract
// - left/right masks from operands' low three bits
// - 64-bit mode: upper 61 bits equal, AND masks
// - 32-bit mode: bits 31:3 equal, AND masks
// - otherwise write left edge mask only
// - mask in low 2, 4 or 8 bits
// - flag variants set codes like subtract
// - little-endian mask is bit-reversed big-endian
// - left mask: ones from offset to LSB
// - flag opf codes 0x00/0x04/0x08, bit1 little-endian
// - opf bit0 set: same mask, codes unchanged
// - decode only op3 110110 with standard fields
`default_nettype none
module pixel_edge_mask_unit
(
    // clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        clk_en,
    // issue from the pipeline
    input  wire logic        issue_valid,
    input  wire logic [31:0] instr,
    input  wire logic [63:0] first_source_operand,
    input  wire logic [63:0] second_source_operand,
    input  wire logic        addr_mask_32_enable,
    // writeback of the destination register
    output logic             result_valid,
    output logic      [4:0]  result_rd,
    output logic      [63:0] result_data,
    // condition code update {xcc n z v c, icc n z v c}
    output logic             ccr_write,
    output logic      [7:0]  ccr_value
);
    import edge_pkg::*;

    // reset release through two flops
    logic rst_meta_reg;
    logic rst_sync_reg;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // instruction fields
    logic [OP_W-1:0]  f_op;
    logic [OP3_W-1:0] f_op3;
    logic [OPF_W-1:0] f_opf;
    logic [RD_W-1:0]  f_rd;
    elem_size_t       size;
    logic             is_edge;
    logic             no_flags;
    logic             little;
    assign f_op     = instr[OP_LSB +: OP_W];
    assign f_op3    = instr[OP3_LSB +: OP3_W];
    assign f_opf    = instr[OPF_LSB +: OPF_W];
    assign f_rd     = instr[RD_LSB +: RD_W];
    assign size     = elem_size_t'(f_opf[OPF_SIZE_LSB +: 2]);
    assign no_flags = f_opf[OPF_NOFLAGS_BIT];
    assign little   = f_opf[OPF_LE_BIT];
    // recognise the twelve edge encodings
    assign is_edge  = (f_op == OP_ARITH) && (f_op3 == OP3_EDGE)
                      && (f_opf[OPF_HI_LSB +: OPF_HI_W] == OPF_HI_EDGE)
                      && (size != SZ_BAD);

    // same scan line test under the address mode
    logic same_line;
    assign same_line = addr_mask_32_enable
        ? (first_source_operand[ADDR32_MSB:LINE_LSB] == second_source_operand[ADDR32_MSB:LINE_LSB])
        : (first_source_operand[63:LINE_LSB] == second_source_operand[63:LINE_LSB]);

    logic [7:0] mask;
    edge_mask_gen u_mask
    (
        .size          (size),
        .little_endian (little),
        .left_off      (first_source_operand[2:0]),
        .right_off     (second_source_operand[2:0]),
        .same_line     (same_line),
        .mask          (mask)
    );

    // subtract for condition codes
    logic [64:0] diff;
    logic [32:0] diff32;
    logic [3:0]  xcc;
    logic [3:0]  icc;
    assign diff   = {1'b0, first_source_operand} - {1'b0, second_source_operand};
    assign diff32 = {1'b0, first_source_operand[31:0]} - {1'b0, second_source_operand[31:0]};
    assign xcc = {diff[63], diff[63:0] == 64'h0,
                  (first_source_operand[63] != second_source_operand[63]) && (diff[63] != first_source_operand[63]),
                  diff[64]};
    assign icc = {diff32[31], diff32[31:0] == 32'h0,
                  (first_source_operand[31] != second_source_operand[31]) && (diff32[31] != first_source_operand[31]),
                  diff32[32]};

    // output register next values
    logic        valid_reg, valid_next;
    logic [4:0]  rd_reg, rd_next;
    logic [63:0] data_reg, data_next;
    logic        ccw_reg, ccw_next;
    logic [7:0]  ccr_reg, ccr_next;
    always_comb
    begin
        valid_next = 1'b0;
        rd_next    = rd_reg;
        data_next  = data_reg;
        ccw_next   = 1'b0;
        ccr_next   = ccr_reg;
        if (issue_valid && is_edge)
        begin
            valid_next = 1'b1;
            rd_next    = f_rd;
            data_next  = {56'h0, mask};
            ccw_next   = !no_flags;
            if (!no_flags)
            begin
                ccr_next = {xcc, icc};
            end
        end
    end

    // output registers, frozen while enable is low
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            valid_reg <= 1'b0;
            rd_reg    <= RD_RST;
            data_reg  <= RESULT_RST;
            ccw_reg   <= 1'b0;
            ccr_reg   <= CCR_RST;
        end
        else if (!rst_sync_reg)
        begin
            valid_reg <= 1'b0;
            rd_reg    <= RD_RST;
            data_reg  <= RESULT_RST;
            ccw_reg   <= 1'b0;
            ccr_reg   <= CCR_RST;
        end
        else if (clk_en)
        begin
            valid_reg <= valid_next;
            rd_reg    <= rd_next;
            data_reg  <= data_next;
            ccw_reg   <= ccw_next;
            ccr_reg   <= ccr_next;
        end
    end

    assign result_valid = valid_reg;
    assign result_rd    = rd_reg;
    assign result_data  = data_reg;
    assign ccr_write    = ccw_reg;
    assign ccr_value    = ccr_reg;

    // checks, one enabled cycle after issue
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sync_reg);

    sequence s_edge(logic [8:0] opf);
        clk_en && issue_valid && f_op == 2'h2 && f_op3 == 6'h36 && f_opf == opf;
    endsequence
    sequence s_split;
        first_source_operand[63:3] != second_source_operand[63:3] && !addr_mask_32_enable;
    endsequence

    a_edge_result_latency: assert property (s_edge(9'h000) |=> result_valid && result_rd == $past(f_rd))
        else $error("edge result not written one cycle after issue");
    a_other_op_quiet: assert property (clk_en && issue_valid && f_op3 != 6'h36 |=> !result_valid)
        else $error("non-edge op produced a result");
    a_mask_low_bits: assert property (result_valid |-> result_data[63:8] == 56'h0)
        else $error("result mask leaks above bit 7");
    a_word_mask_width: assert property (s_edge(9'h008) |=> result_data[7:2] == 6'h00)
        else $error("word edge mask wider than two bits");
    a_left_only_byte: assert property (
        s_edge(9'h000) ##0 s_split ##0 first_source_operand[2:0] == 3'h1
        |=> result_data[7:0] == 8'h7F)
        else $error("left edge byte mask wrong");
    a_left_half_mask: assert property (
        s_edge(9'h004) ##0 s_split ##0 first_source_operand[2:1] == 2'h1
        |=> result_data[3:0] == 4'h7)
        else $error("left edge half mask wrong");
    a_little_reverse: assert property (
        s_edge(9'h002) ##0 s_split ##0 first_source_operand[2:0] == 3'h1
        |=> result_data[7:0] == 8'hFE)
        else $error("little-endian mask not reversed");
    a_half_le_reverse: assert property (
        s_edge(9'h006) ##0 s_split ##0 first_source_operand[2:1] == 2'h1
        |=> result_data[3:0] == 4'hE)
        else $error("little-endian half mask not reversed");
    a_same_line_and: assert property (
        s_edge(9'h000) ##0 !addr_mask_32_enable && first_source_operand == second_source_operand
        |=> $onehot(result_data[7:0]))
        else $error("same-line mask not ANDed");
    a_addr32_and: assert property (
        s_edge(9'h001) ##0 addr_mask_32_enable && first_source_operand[31:0] == 32'h0000_0000
        && second_source_operand[31:0] == 32'h0000_0003
        |=> result_data[7:0] == 8'hF0)
        else $error("32-bit mode line match not honoured");
    a_word_right_mask: assert property (
        s_edge(9'h008) ##0 !addr_mask_32_enable && !first_source_operand[2]
        && first_source_operand[63:2] == second_source_operand[63:2]
        |=> result_data[1:0] == 2'h2)
        else $error("word right edge mask wrong");
    a_flags_written: assert property (
        s_edge(9'h000) ##0 first_source_operand == second_source_operand
        |=> ccw_reg && ccr_value[6] && ccr_value[2])
        else $error("flag variant did not set zero flags");
    a_carry_borrow: assert property (
        s_edge(9'h000) ##0 (first_source_operand < second_source_operand) |=> ccr_value[4])
        else $error("borrow not reported in carry flag");
    a_noflags_hold: assert property (s_edge(9'h001) |=> !ccr_write && $stable(ccr_value))
        else $error("no-flag variant touched condition codes");
    a_result_hold: assert property (
        !(clk_en && issue_valid && is_edge) |=> $stable(result_rd) && $stable(result_data))
        else $error("result changed without an accepted edge op");
endmodule // pixel_edge_mask_unit
`default_nettype wire

//--- verilog/edge_pkg.sv
`default_nettype none
package edge_pkg;
    // instruction field positions and widths
    localparam int OP_LSB    = 30;
    localparam int OP_W      = 2;
    localparam int RD_LSB    = 25;
    localparam int RD_W      = 5;
    localparam int OP3_LSB   = 19;
    localparam int OP3_W     = 6;
    localparam int OPF_LSB   = 5;
    localparam int OPF_W     = 9;
    // opf sub-fields
    localparam int OPF_NOFLAGS_BIT = 0;
    localparam int OPF_LE_BIT      = 1;
    localparam int OPF_SIZE_LSB    = 2;
    localparam int OPF_HI_LSB      = 4;
    localparam int OPF_HI_W        = 5;
    // encodings of the edge group
    localparam logic [1:0] OP_ARITH   = 2'h2;
    localparam logic [5:0] OP3_EDGE   = 6'h36;
    localparam logic [4:0] OPF_HI_EDGE = 5'h00;
    // address comparison ranges
    localparam int LINE_LSB     = 3;
    localparam int ADDR32_MSB   = 31;
    // reset values
    localparam logic [63:0] RESULT_RST = 64'h0;
    localparam logic [7:0]  CCR_RST    = 8'h00;
    localparam logic [4:0]  RD_RST     = 5'h00;

    // element size selected by opf bits 3:2
    typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD, SZ_BAD} elem_size_t;
endpackage
`default_nettype wire

//--- verilog/edge_mask_gen.sv
`default_nettype none
module edge_mask_gen
(
    // operation select
    input  wire edge_pkg::elem_size_t size,
    input  wire logic                 little_endian,
    // address offsets and line match
    input  wire logic [2:0]           left_off,
    input  wire logic [2:0]           right_off,
    input  wire logic                 same_line,
    // mask in low bits
    output logic      [7:0]           mask
);
    import edge_pkg::*;

    logic [7:0] left_m;
    logic [7:0] right_m;
    logic [7:0] be_m;
    logic [7:0] rev8;
    logic [7:0] rev4;
    logic [7:0] rev2;

    // left and right big-endian masks per element size
    always_comb
    begin
        left_m  = 8'h00;
        right_m = 8'h00;
        case (size)
            SZ_BYTE:
            begin
                left_m  = 8'hFF >> left_off;
                right_m = 8'hFF << (3'h7 - right_off);
            end
            SZ_HALF:
            begin
                left_m  = {4'h0, 4'hF >> left_off[2:1]};
                right_m = {4'h0, 4'(4'hF << (2'h3 - right_off[2:1]))};
            end
            SZ_WORD:
            begin
                left_m  = {6'h00, 2'h3 >> left_off[2]};
                right_m = {6'h00, 2'(2'h3 << (1'h1 - right_off[2]))};
            end
            default:
            begin
                left_m  = 8'h00;
                right_m = 8'h00;
            end
        endcase
        be_m = same_line ? (left_m & right_m) : left_m;
    end

    // bit reversal within the element mask width
    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_rev
            assign rev8[i] = be_m[7 - i];
            assign rev4[i] = (i < 4) ? be_m[(3 - i) & 3] : 1'b0;
            assign rev2[i] = (i < 2) ? be_m[(1 - i) & 1] : 1'b0;
        end
    endgenerate

    // little-endian selects the reversed form
    always_comb
    begin
        mask = be_m;
        if (little_endian)
        begin
            case (size)
                SZ_BYTE: mask = rev8;
                SZ_HALF: mask = rev4;
                SZ_WORD: mask = rev2;
                default: mask = 8'h00;
            endcase
        end
    end
endmodule // edge_mask_gen
`default_nettype wire

//--- dv/pipe_issue_model.sv
`default_nettype none
module pipe_issue_model
(
    // clock
    input  wire logic        clk,
    // issue towards the unit
    output var  logic        clk_en,
    output var  logic        issue_valid,
    output var  logic [31:0] instr,
    output var  logic [63:0] first_source_operand,
    output var  logic [63:0] second_source_operand,
    output var  logic        addr_mask_32_enable
);
    timeunit 1ns;
    timeprecision 1ps;

    // quiet pipeline at time zero
    initial
    begin
        clk_en                = 1'b1;
        issue_valid           = 1'b0;
        instr                 = 32'h0;
        first_source_operand  = 64'h0;
        second_source_operand = 64'h0;
        addr_mask_32_enable   = 1'b0;
    end

    // one issue slot; an idle slot shows inverted operands, not stale ones
    task automatic issue(input logic en, input logic v, input logic [31:0] w,
                         input logic [63:0] a, input logic [63:0] b, input logic am);
        @(posedge clk);
        clk_en                <= en;
        issue_valid           <= v;
        instr                 <= v ? w : ~w;
        first_source_operand  <= v ? a : ~a;
        second_source_operand <= v ? b : ~b;
        addr_mask_32_enable   <= am;
    endtask
endmodule // pipe_issue_model
`default_nettype wire

//--- dv/pixel_edge_mask_unit_test.sv
`default_nettype none
module pixel_edge_mask_unit_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk;
    logic        rstn;
    logic        clk_en;
    logic        issue_valid;
    logic [31:0] instr;
    logic [63:0] opa;
    logic [63:0] opb;
    logic        am;
    logic        result_valid;
    logic [4:0]  result_rd;
    logic [63:0] result_data;
    logic        ccr_write;
    logic [7:0]  ccr_value;
    int          failures;
    int          n_compared;
    logic [7:0]  lastcc;
    logic [77:0] expq[$];

    // clock generator
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    pipe_issue_model pipe (.clk(clk), .clk_en(clk_en), .issue_valid(issue_valid), .instr(instr),
        .first_source_operand(opa), .second_source_operand(opb), .addr_mask_32_enable(am));

    pixel_edge_mask_unit dut (.clk(clk), .rstn(rstn), .clk_en(clk_en), .issue_valid(issue_valid),
        .instr(instr), .first_source_operand(opa), .second_source_operand(opb),
        .addr_mask_32_enable(am), .result_valid(result_valid), .result_rd(result_rd),
        .result_data(result_data), .ccr_write(ccr_write), .ccr_value(ccr_value));

    // single comparison point
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        if (failures == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // expected mask from address offsets and line match
    function automatic logic [7:0] emask(input logic [1:0] sz, input logic le, input logic [63:0] a,
                                         input logic [63:0] b, input logic m32);
        int         n;
        logic [7:0] all;
        logic [7:0] l;
        logic [7:0] r;
        logic [7:0] m;
        logic [7:0] o;
        n = 8 >> sz;
        all = 8'hFF >> (8 - n);
        l = all >> (a[2:0] >> sz);
        r = (all << (n - 1 - (b[2:0] >> sz))) & all;
        if (m32 ? (a[31:3] == b[31:3]) : (a[63:3] == b[63:3]))
            m = l & r;
        else
            m = l;
        o = m;
        for (int i = 0; i < n; i++)
            if (le)
                o[i] = m[n - 1 - i];
        return o;
    endfunction

    // flags of first minus second, 64-bit and 32-bit views
    function automatic logic [7:0] eflags(input logic [63:0] a, input logic [63:0] b);
        logic [63:0] d;
        d = a - b;
        return {d[63], d == 64'h0, (a[63] != b[63]) && (d[63] != a[63]), a < b,
                d[31], d[31:0] == 32'h0, (a[31] != b[31]) && (d[31] != a[31]), a[31:0] < b[31:0]};
    endfunction

    // watcher: each writeback takes the oldest note, mid-cycle where outputs are settled
    always @(negedge clk)
    begin
        if (result_valid === 1'b1)
        begin
            if (expq.size() == 0)
                check(64'h1, 64'h0);
            else
            begin
                check(result_rd, expq[0][77:73]);
                check(result_data, {56'h0, expq[0][72:65]});
                check(ccr_write, expq[0][64]);
                check(ccr_value, expq[0][63:56]);
                void'(expq.pop_front());
            end
        end
        else if (rstn === 1'b1)
            check(ccr_write, 1'b0);
    end

    // note the expected result, then issue the edge instruction
    task automatic put(input logic [8:0] opf, input logic [4:0] rd, input logic [63:0] a,
                       input logic [63:0] b, input logic m32);
        if (opf[0] == 1'b0)
            lastcc = eflags(a, b);
        expq.push_back({rd, emask(opf[3:2], opf[1], a, b, m32), ~opf[0], lastcc, 56'h0});
        pipe.issue(1'b1, 1'b1, {2'h2, rd, 6'h36, 5'($urandom), opf, 5'($urandom)}, a, b, m32);
    endtask

    // bounded wait until every note is taken; a timeout counts as a mismatch
    task automatic drain();
        pipe.issue(1'b1, 1'b0, 32'h0, 64'h0, 64'h0, 1'b0);
        for (int w = 0; w < 10 && expq.size() != 0; w++)
            @(posedge clk);
        if (expq.size() != 0)
            failures++;
    endtask

    // main sequence
    initial
    begin
        logic [63:0] a;
        logic [63:0] b;
        logic [8:0]  opf;
        logic [4:0]  rd;
        logic        m32;
        int          v;
        int          k;
        rstn = 1'b0;
        failures = 0;
        n_compared = 0;
        lastcc = 8'h00;
        void'($urandom(43876));
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        // directed corner masks: left only, little-endian, same line, 32-bit match, word right edge
        put(9'h000, 5'h01, 64'h1000_0000_0000_0001, 64'h2000_0000_0000_0005, 1'b0);
        put(9'h004, 5'h02, 64'h1000_0000_0000_0002, 64'h2000_0000_0000_0007, 1'b0);
        put(9'h002, 5'h03, 64'h1000_0000_0000_0001, 64'h2000_0000_0000_0005, 1'b0);
        put(9'h006, 5'h04, 64'h1000_0000_0000_0002, 64'h2000_0000_0000_0007, 1'b0);
        put(9'h000, 5'h05, 64'h0000_0000_0000_0123, 64'h0000_0000_0000_0123, 1'b0);
        put(9'h001, 5'h06, 64'hAAAA_0000_0000_0000, 64'h5555_0000_0000_0003, 1'b1);
        put(9'h008, 5'h07, 64'h0000_0000_0000_0040, 64'h0000_0000_0000_0041, 1'b0);
        for (int t = 0; t < 600; t++)
        begin
            if (t == 300)
            begin
                // second reset in mid-run; the codes return to their reset value
                drain();
                rstn <= 1'b0;
                repeat (4) @(posedge clk);
                rstn <= 1'b1;
                lastcc = 8'h00;
                repeat (2) @(posedge clk);
            end
            v = $urandom % 12;
            opf = {5'h00, 2'(v % 3), 1'((v / 3) % 2), 1'(v / 6)};
            rd = 5'($urandom);
            a = {$urandom, $urandom};
            k = $urandom % 3;
            b = (k == 0) ? {$urandom, $urandom} : (k == 1) ? {a[63:3], 3'($urandom)}
                : {$urandom, a[31:3], 3'($urandom)};
            m32 = 1'($urandom);
            k = $urandom % 10;
            if (k < 4)
            begin
                // refused: wrong op3, bad size, wrong format, or unit held
                pipe.issue(1'b1, 1'b0, 32'h0, a, b, m32);
                pipe.issue(k != 3, 1'b1, {(k == 2) ? 2'h3 : 2'h2, rd, (k == 0) ? 6'h37 : 6'h36, 5'h00,
                    (k == 1) ? 9'h00C : opf, 5'h00}, a, b, m32);
                pipe.issue(1'b1, 1'b0, 32'h0, a, b, m32);
            end
            else
                put(opf, rd, a, b, m32);
        end
        drain();
        test_done();
    end
endmodule // pixel_edge_mask_unit_test
`default_nettype wire
